// File: ompl_map.svh
// Function
// - Opcode high byte 0000 1001 ORs the accumulator with the low-byte immediate, writes the accumulator and updates both flags.
// - Opcode top bits 0001 00 ORs the accumulator with the addressed data register and updates both flags.
// - Target bit 0 sends the result to the accumulator, target bit 1 writes it back to the addressed data register.
// - Selector bit 0 addresses the fixed common bank and ignores the bank select register.
// - Selector bit 1 forms the address from the bank select register and the 8-bit operand location.
// - The pointer load is two words, 1110 1110 with index and upper nibble, then 1111 0000 with the low byte, over two cycles.
// - The pointer load index picks one of three pointers, 0 to 2, and carries a 12-bit immediate 0 to 4095.
// - Opcode top bits 0101 00 copies the addressed register to the chosen target and updates both flags.
// - The 8-bit operand location reaches any byte of a 256-byte bank.
`ifndef OMPL_MAP_SVH
`define OMPL_MAP_SVH

`define OMPL_OP_OR_IMM 8'h09
`define OMPL_OP_OR_REG 6'h04
`define OMPL_OP_MOVE 6'h14
`define OMPL_OP_PTR_FIRST 8'hEE
`define OMPL_OP_PTR_SECOND 8'hF0
`define OMPL_PTR_ZERO_BITS 2'h0
`define OMPL_DEST_BIT 9
`define OMPL_BANK_BIT 8
`define OMPL_PTR_IDX_HI 5
`define OMPL_PTR_IDX_LO 4
`define OMPL_PTR_COUNT 2'h3
`define OMPL_ACCESS_BANK 4'h0
`define OMPL_ACC_RESET 8'h00
`define OMPL_PTR_RESET 12'h000
`define OMPL_ADDR_RESET 12'h000

`endif

// File: ompl_pkg.sv
package ompl_pkg;

	// gray order along the four phases
	typedef enum logic [1:0] {
		OMPL_Q1 = 2'h0,
		OMPL_Q2 = 2'h1,
		OMPL_Q3 = 2'h3,
		OMPL_Q4 = 2'h2
	} ompl_phase_e;

	typedef enum logic [2:0] {
		OMPL_NONE = 3'h0,
		OMPL_OR_IMM = 3'h1,
		OMPL_OR_REG = 3'h2,
		OMPL_MOVE = 3'h3,
		OMPL_PTR_HI = 3'h4,
		OMPL_PTR_LO = 3'h5
	} ompl_op_e;

	typedef struct packed {
		ompl_op_e op;
		logic dest;
		logic useBank;
		logic [7:0] operand;
		logic [1:0] ptrIdx;
	} ompl_dec_s;

	typedef struct packed {
		logic [7:0] acc;
		logic msbSet;
		logic allClear;
	} ompl_core_s;

endpackage : ompl_pkg

// File: ompl_decode.sv
`timescale 1ns/1ps
`include "ompl_map.svh"
module ompl_decode (
	// instruction word
	input wire logic [15:0] instrWord,
	// pointer load second word expected
	input wire logic pendingLow,
	input wire logic [1:0] heldIdx,
	// decoded fields
	output ompl_pkg::ompl_dec_s dec
);
	import ompl_pkg::*;

	wire isOrImm = instrWord[15:8] == `OMPL_OP_OR_IMM;
	wire isOrReg = instrWord[15:10] == `OMPL_OP_OR_REG;
	wire isMove = instrWord[15:10] == `OMPL_OP_MOVE;
	wire isPtrFirst = (instrWord[15:8] == `OMPL_OP_PTR_FIRST)
		&& (instrWord[7:6] == `OMPL_PTR_ZERO_BITS);
	wire isPtrSecond = instrWord[15:8] == `OMPL_OP_PTR_SECOND;

	// a stray second word outside a pointer load does nothing, as does any word
	// other than the second one while it is awaited
	wire ompl_op_e opSel = pendingLow ? (isPtrSecond ? OMPL_PTR_LO : OMPL_NONE) :
		isOrImm ? OMPL_OR_IMM :
		isOrReg ? OMPL_OR_REG :
		isMove ? OMPL_MOVE :
		isPtrFirst ? OMPL_PTR_HI : OMPL_NONE;

	assign dec.op = opSel;
	assign dec.dest = instrWord[`OMPL_DEST_BIT];
	assign dec.useBank = instrWord[`OMPL_BANK_BIT];
	assign dec.operand = instrWord[7:0];
	assign dec.ptrIdx = pendingLow ? heldIdx : instrWord[`OMPL_PTR_IDX_HI:`OMPL_PTR_IDX_LO];

endmodule : ompl_decode

// File: or_move_pointer_load_exec.sv
`timescale 1ns/1ps
`include "ompl_map.svh"
module or_move_pointer_load_exec (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// instruction stream
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	output logic instrReady,
	// bank selector from the core
	input wire logic [3:0] bankSelect,
	// data memory, read data arrives the phase after the address
	output logic [11:0] memAddr,
	output logic memRdEn,
	input wire logic [7:0] memRdData,
	output logic memWrEn,
	output logic [7:0] memWrData,
	// core state
	output ompl_pkg::ompl_core_s coreState,
	output logic [2:0][11:0] pointerOut,
	output ompl_pkg::ompl_phase_e phase
);
	import ompl_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// reset release
	logic rstSync1;
	logic rstSync2;
	wire rstN = rstSync2;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase sequencer
	ompl_phase_e next_phase;

	always_comb begin
		case (phase)
			OMPL_Q1: next_phase = OMPL_Q2;
			OMPL_Q2: next_phase = OMPL_Q3;
			OMPL_Q3: next_phase = OMPL_Q4;
			OMPL_Q4: next_phase = OMPL_Q1;
			default: next_phase = OMPL_Q1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) phase <= OMPL_Q1;
		else phase <= next_phase;
	end

	// a word is taken only in the decode phase
	assign instrReady = phase == OMPL_Q1;

	////////////////////////////////////////////////////////////////////////////
	// decode
	ompl_dec_s decWord;
	ompl_dec_s decReg;
	logic pendingLow;
	logic [1:0] heldIdx;
	logic [7:0] accReg;
	logic [7:0] resultReg;
	logic msbSet;
	logic allClear;
	logic [11:0] ptrReg [0:2];

	ompl_decode uDecode (
		.instrWord(instrWord),
		.pendingLow(pendingLow),
		.heldIdx(heldIdx),
		.dec(decWord)
	);

	// ready stands through reset, so the word is gated here until release
	wire takeWord = instrReady && instrValid && rstN;
	wire decIsReg = (decWord.op == OMPL_OR_REG) || (decWord.op == OMPL_MOVE);
	wire regIsReg = (decReg.op == OMPL_OR_REG) || (decReg.op == OMPL_MOVE);
	wire regSetsFlags = regIsReg || (decReg.op == OMPL_OR_IMM);
	wire [3:0] bankUsed = decWord.useBank ? bankSelect : `OMPL_ACCESS_BANK;
	wire [11:0] addrSel = {bankUsed, decWord.operand};
	wire ptrIdxOk = decReg.ptrIdx < `OMPL_PTR_COUNT;

	function automatic logic [7:0] execResult(input ompl_op_e op, input logic [7:0] acc,
		input logic [7:0] imm, input logic [7:0] rd);
		case (op)
			OMPL_OR_IMM: execResult = acc | imm;
			OMPL_OR_REG: execResult = acc | rd;
			OMPL_MOVE: execResult = rd;
			default: execResult = acc;
		endcase
	endfunction : execResult

	wire [7:0] aluOut = execResult(decReg.op, accReg, decReg.operand, memRdData);

	////////////////////////////////////////////////////////////////////////////
	// Q1 edge: latch decode, present operand address
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			decReg <= '0;
			memAddr <= `OMPL_ADDR_RESET;
			memRdEn <= 1'b0;
		end else if (phase == OMPL_Q1) begin
			decReg <= takeWord ? decWord : '0;
			memAddr <= addrSel;
			memRdEn <= takeWord && decIsReg;
		end else begin
			memRdEn <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Q3 edge: process, Q4 holds the write strobe to memory
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			resultReg <= `OMPL_ACC_RESET;
			memWrData <= `OMPL_ACC_RESET;
			memWrEn <= 1'b0;
		end else if (phase == OMPL_Q3) begin
			resultReg <= aluOut;
			memWrData <= aluOut;
			memWrEn <= regIsReg && decReg.dest;
		end else begin
			memWrEn <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Q4 edge: accumulator, flags and pointers
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			accReg <= `OMPL_ACC_RESET;
			msbSet <= 1'b0;
			allClear <= 1'b0;
		end else if (phase == OMPL_Q4) begin
			if (decReg.op == OMPL_OR_IMM || (regIsReg && !decReg.dest)) accReg <= resultReg;
			if (regSetsFlags) begin
				msbSet <= resultReg[7];
				allClear <= resultReg == 8'h00;
			end
		end
	end

	// the second word must follow directly; any other word cancels the wait,
	// and a first word with index 3 opens no wait at all
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			pendingLow <= 1'b0;
			heldIdx <= 2'h0;
		end else if (phase == OMPL_Q4) begin
			pendingLow <= (decReg.op == OMPL_PTR_HI) && ptrIdxOk;
			heldIdx <= decReg.ptrIdx;
		end
	end

	// index 3 is not a pointer, so its loads are dropped
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < 3; i++) ptrReg[i] <= `OMPL_PTR_RESET;
		end else if (phase == OMPL_Q4 && ptrIdxOk) begin
			if (decReg.op == OMPL_PTR_HI) ptrReg[decReg.ptrIdx][11:8] <= decReg.operand[3:0];
			if (decReg.op == OMPL_PTR_LO) ptrReg[decReg.ptrIdx][7:0] <= decReg.operand;
		end
	end

	assign coreState.acc = accReg;
	assign coreState.msbSet = msbSet;
	assign coreState.allClear = allClear;
	assign pointerOut[0] = ptrReg[0];
	assign pointerOut[1] = ptrReg[1];
	assign pointerOut[2] = ptrReg[2];

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_phaseOrder;
		@(posedge clk_sys) disable iff (!rstN)
		rstN && phase == OMPL_Q1 |=> phase == OMPL_Q2 ##1 phase == OMPL_Q3 ##1 phase == OMPL_Q4;
	endproperty
	a_phaseOrder: assert property (p_phaseOrder) else $error("phase order broken");

	property p_orImm;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q3 && decReg.op == OMPL_OR_IMM)
			|=> ##1 accReg == ($past(accReg, 2) | $past(decReg.operand, 2));
	endproperty
	a_orImm: assert property (p_orImm) else $error("immediate or result wrong");

	property p_orReg;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q3 && decReg.op == OMPL_OR_REG)
			|=> resultReg == ($past(accReg) | $past(memRdData));
	endproperty
	a_orReg: assert property (p_orReg) else $error("register or result wrong");

	property p_move;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q3 && decReg.op == OMPL_MOVE) |=> resultReg == $past(memRdData);
	endproperty
	a_move: assert property (p_move) else $error("move result wrong");

	property p_destMem;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q4 && regIsReg && decReg.dest)
			|-> memWrEn && memWrData == resultReg ##1 accReg == $past(accReg);
	endproperty
	a_destMem: assert property (p_destMem) else $error("write back to register wrong");

	property p_destAcc;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q4 && regIsReg && !decReg.dest) |-> !memWrEn ##1 accReg == $past(resultReg);
	endproperty
	a_destAcc: assert property (p_destAcc) else $error("write to accumulator wrong");

	property p_accessBank;
		@(posedge clk_sys) disable iff (!rstN)
		(takeWord && decIsReg && !decWord.useBank) |=> memRdEn && memAddr[11:8] == `OMPL_ACCESS_BANK;
	endproperty
	a_accessBank: assert property (p_accessBank) else $error("common bank not used");

	property p_bankSel;
		@(posedge clk_sys) disable iff (!rstN)
		(takeWord && decIsReg && decWord.useBank)
			|=> memAddr == {$past(bankSelect), $past(instrWord[7:0])};
	endproperty
	a_bankSel: assert property (p_bankSel) else $error("banked address wrong");

	property p_flags;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q4 && regSetsFlags)
			|=> msbSet == $past(resultReg[7]) && allClear == ($past(resultReg) == 8'h00);
	endproperty
	a_flags: assert property (p_flags) else $error("flag update wrong");

	property p_ptrHigh;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q4 && decReg.op == OMPL_PTR_HI && ptrIdxOk)
			|=> pointerOut[$past(decReg.ptrIdx)][11:8] == $past(decReg.operand[3:0]) && pendingLow;
	endproperty
	a_ptrHigh: assert property (p_ptrHigh) else $error("pointer high byte wrong");

	property p_ptrLow;
		@(posedge clk_sys) disable iff (!rstN)
		(phase == OMPL_Q4 && decReg.op == OMPL_PTR_LO && ptrIdxOk)
			|=> pointerOut[$past(decReg.ptrIdx)][7:0] == $past(decReg.operand) && !pendingLow;
	endproperty
	a_ptrLow: assert property (p_ptrLow) else $error("pointer low byte wrong");

endmodule : or_move_pointer_load_exec

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ompl_pkg::*;
	logic clk_sys, resetn, instrValid, instrReady, memRdEn, memWrEn;
	logic [15:0] instrWord;
	logic [3:0] bankSelect;
	logic [11:0] memAddr;
	logic [7:0] memRdData, memWrData, expAcc;
	ompl_core_s coreState;
	logic [2:0][11:0] pointerOut;
	ompl_phase_e phase;
	logic [7:0] mem [0:4095];
	logic [11:0] expPtr [0:2];
	logic expMsb, expZero, waitLow;
	logic [1:0] waitIdx;
	integer seed = 90222;
	integer fail_count = 0;
	integer n_tests = 0;
	integer k;
	logic [31:0] rnd;
	logic [15:0] w;
	logic [15:0] corners [0:12] = '{16'h0900, 16'hEEEF, 16'hF0FF, 16'hEE0A, 16'h0912, 16'hF055,
		16'hEE3B, 16'hF044, 16'h51FF, 16'h0935, 16'h1280, 16'h5280, 16'h1100};

	or_move_pointer_load_exec u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
		.bankSelect(bankSelect), .memAddr(memAddr), .memRdEn(memRdEn),
		.memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData),
		.coreState(coreState), .pointerOut(pointerOut), .phase(phase));

	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end

	// data memory: read data only valid in the cycle after the read strobe
	always @(posedge clk_sys) begin
		if (memWrEn === 1'b1) mem[memAddr] <= memWrData;
		memRdData <= (memRdEn === 1'b1) ? mem[memAddr] : ~memRdData;
	end

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task test_done;
		$display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	task do_reset;
		resetn = 0;
		instrValid = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(coreState === '0 && pointerOut === '0, "reset state");
		resetn = 1;
		expAcc = 0; expMsb = 0; expZero = 0; waitLow = 0;
		for (k = 0; k < 3; k++) expPtr[k] = 0;
		// first word is taken at the third edge after release
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : do_reset

	task automatic exec(input logic [15:0] w, input logic [3:0] bank);
		integer i;
		logic [11:0] a;
		logic [7:0] r, rv;
		logic isReg, upd, skip;
		ompl_phase_e ph [0:3];
		ph = '{OMPL_Q2, OMPL_Q3, OMPL_Q4, OMPL_Q1};
		i = 0;
		while (phase !== OMPL_Q1 && i < 8) begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		chk(instrReady === 1'b1, "no slot");
		instrWord = w;
		instrValid = 1;
		bankSelect = bank;
		a = {w[8] ? bank : 4'h0, w[7:0]};
		isReg = (w[15:10] == 6'h04) || (w[15:10] == 6'h14);
		rv = mem[a];
		skip = waitLow;
		upd = 0;
		if (waitLow && w[15:8] == 8'hF0) expPtr[waitIdx][7:0] = w[7:0];
		waitLow = 0;
		if (!skip) begin
			if (w[15:8] == 8'h09) begin
				r = expAcc | w[7:0];
				upd = 1;
			end else if (isReg) begin
				r = w[14] ? rv : (expAcc | rv);
				upd = 1;
			end else if (w[15:6] == 10'h3B8 && w[5:4] != 2'h3) begin
				expPtr[w[5:4]][11:8] = w[3:0];
				waitLow = 1;
				waitIdx = w[5:4];
			end
		end
		if (upd) begin
			expMsb = r[7];
			expZero = (r == 8'h00);
			if (!(isReg && w[9])) expAcc = r;
		end
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			#1;
			if (i == 0) instrValid = 0;
			if (i == 0) instrWord = ~w;
			chk(phase === ph[i], "phase order");
			if (i == 0 && isReg && !skip) chk(memAddr === a, "data address");
		end
		chk(coreState.acc === expAcc, "accumulator");
		chk(coreState.msbSet === expMsb && coreState.allClear === expZero, "flags");
		if (isReg && !skip) chk(mem[a] === ((upd && w[9]) ? r : rv), "register");
		for (i = 0; i < 3; i++) chk(pointerOut[i] === expPtr[i], "pointer");
	endtask : exec

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 0;
		instrWord = 16'h0000;
		instrValid = 0;
		bankSelect = 4'h0;
		for (k = 0; k < 4096; k++) mem[k] = 8'($random(seed));
		mem[12'hFFF] = 8'h00;
		do_reset();
		for (k = 0; k < 13; k++) exec(corners[k], 4'hF);
		for (k = 0; k < 80; k++) begin
			rnd = $random(seed);
			w = rnd[15:0];
			case (rnd[18:16])
				3'h0, 3'h1: w[15:8] = 8'h09;
				3'h2: w[15:10] = 6'h04;
				3'h3: w[15:10] = 6'h14;
				3'h4: w[15:6] = 10'h3B8;
				3'h5: w[15:8] = 8'hF0;
				default: w[15:8] = 8'hEE;
			endcase
			exec(w, rnd[23:20]);
			if (rnd[18:16] == 3'h4) exec({8'hF0, rnd[31:24]}, rnd[27:24]);
		end
		do_reset();
		exec(16'h0980, 4'h0);
		test_done();
	end

	initial begin
		#3000000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end
endmodule : tb_top
